// file: hdl/itbs_pkg.sv
// constants, types and carriers for the interrupt source and time base block
// assumes a single 40 MHz core clock and an AXI4-Lite register master
package itbs_pkg;
    localparam int ITBS_AW = 5;
    localparam logic [4:0] ITBS_OFS_ENA = 5'h00;
    localparam logic [4:0] ITBS_OFS_FLAG = 5'h04;
    localparam logic [4:0] ITBS_OFS_TBC = 5'h08;
    localparam logic [4:0] ITBS_OFS_STAT = 5'h0C;
    localparam logic [1:0] ITBS_RESP_OKAY = 2'h0;
    localparam logic [1:0] ITBS_RESP_SLVERR = 2'h2;

    // flag and enable layout, lowest index has highest priority
    localparam int ITBS_NFLG = 7;
    localparam int ITBS_NGRP = 3;
    localparam int ITBS_GSRC = 4;
    localparam int ITBS_F_CMP = 0;
    localparam int ITBS_F_GRP = 1;
    localparam int ITBS_F_CONV = 4;
    localparam int ITBS_F_TBA = 5;
    localparam int ITBS_F_TBB = 6;
    localparam int ITBS_ENA_GIE = 7;

    // time_base_control fields
    localparam int ITBS_TBC_RUN = 7;
    localparam int ITBS_TBC_CKS = 6;
    localparam int ITBS_TBC_BP_LSB = 4;
    localparam int ITBS_TBC_LP = 3;
    localparam int ITBS_TBC_AP_LSB = 0;
    localparam logic [7:0] ITBS_TBC_RST = 8'h37;

    localparam int ITBS_TB_W = 15;
    localparam logic [14:0] ITBS_TB_FULL = 15'h7FFF;
    localparam logic [2:0] ITBS_TBA_SEL_MAX = 3'h7;
    localparam logic [1:0] ITBS_TBB_SEL_MAX = 2'h3;
    localparam logic [1:0] ITBS_SYS_DIV_LAST = 2'h3;

    typedef enum logic [1:0] {
        ITBS_WR_IDLE = 2'b01,
        ITBS_WR_RESP = 2'b10
    } itbs_wr_st_t;

    typedef struct packed {
        logic awvalid;
        logic [4:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [4:0] araddr;
        logic rready;
    } itbs_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } itbs_axi_rsp_t;

    typedef struct packed {
        logic [6:0] flag;
        logic [7:0] ena;
        logic [7:0] time_base_control;
        logic [2:0] vid;
        logic wake;
        logic cmp_prev;
        logic osc_prev;
        logic [1:0] div4;
        logic [2:0][3:0] src_prev;
        logic awv;
        logic [4:0] awa;
        logic wv;
        logic [7:0] wd;
        logic wst0;
        itbs_wr_st_t wst;
        logic [1:0] bresp;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rresp;
    } itbs_state_t;

    typedef struct packed {
        logic [14:0] cnt;
    } itbs_div_t;
endpackage

// file: hdl/itbs_tbdiv.sv
// divider chain shared by both time bases, advanced by a one-cycle tick
// assumes tick is already qualified by the selected time base input clock
`timescale 1ns/100ps
module itbs_tbdiv import itbs_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic tick,
    input wire logic [2:0] a_sel,
    input wire logic [1:0] b_sel,
    output logic ovf_a,
    output logic ovf_b
);
    itbs_div_t s;
    itbs_div_t n;
    logic [14:0] mask_a;
    logic [14:0] mask_b;

    // period is 2**(8+a_sel) and 2**(12+b_sel) input clocks
    assign mask_a = ITBS_TB_FULL >> (ITBS_TBA_SEL_MAX - a_sel);
    assign mask_b = ITBS_TB_FULL >> (ITBS_TBB_SEL_MAX - b_sel);

    // the chain never stops on overflow, it wraps and keeps counting
    always_comb begin
        n = s;
        if (!run) begin
            n.cnt = '0;
        end else if (tick) begin
            n.cnt = s.cnt + 15'h0001;
        end
    end

    assign ovf_a = run && tick && ((s.cnt & mask_a) == mask_a);
    assign ovf_b = run && tick && ((s.cnt & mask_b) == mask_b);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule

// file: hdl/itbs_top.sv
// interrupt request flags, vector arbitration and time base control
// assumes synchronous inputs and a core that acknowledges vec_req with vec_ack
`timescale 1ns/100ps
module itbs_top import itbs_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire itbs_axi_req_t axi_req,
    output itbs_axi_rsp_t axi_rsp,
    input wire logic cmp_out,
    input wire logic conv_done,
    input wire logic [2:0][3:0] group_src_flags,
    input wire logic tbase_osc_clk,
    input wire logic stack_full,
    output logic vec_req,
    output logic [2:0] vec_id,
    input wire logic vec_ack,
    input wire logic irq_return_instr,
    output logic wake_pulse,
    output logic slow_xtal_low_power
);
    itbs_state_t s;
    itbs_state_t n;
    logic [6:0] set_v;
    logic [6:0] clr_sw;
    logic [6:0] svc;
    logic [6:0] pend_n;
    logic tb_tick;
    logic tba_ovf;
    logic tbb_ovf;
    logic svc_go;
    logic ena_wr;

    function automatic logic is_mapped(input logic [4:0] a);
        is_mapped = (a == ITBS_OFS_ENA) || (a == ITBS_OFS_FLAG) ||
                    (a == ITBS_OFS_TBC) || (a == ITBS_OFS_STAT);
    endfunction

    // fixed priority: lowest flag index wins
    function automatic logic [2:0] pick(input logic [6:0] p);
        pick = 3'h0;
        for (int i = ITBS_NFLG - 1; i >= 0; i--) begin
            if (p[i]) begin
                pick = 3'(i);
            end
        end
    endfunction

    // time base input: synchronous oscillator edge or system clock over four
    assign tb_tick = s.time_base_control[ITBS_TBC_CKS] ? (s.div4 == ITBS_SYS_DIV_LAST)
                                         : (tbase_osc_clk && !s.osc_prev);

    itbs_tbdiv u_div (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .run(s.time_base_control[ITBS_TBC_RUN]),
        .tick(tb_tick),
        .a_sel(s.time_base_control[ITBS_TBC_AP_LSB +: 3]),
        .b_sel(s.time_base_control[ITBS_TBC_BP_LSB +: 2]),
        .ovf_a(tba_ovf),
        .ovf_b(tbb_ovf)
    );

    assign svc_go = vec_req && vec_ack;

    // software write to the enable register, the only way besides a return to raise gie
    assign ena_wr = (s.wst == ITBS_WR_IDLE) && s.awv && s.wv && s.wst0 &&
                    (s.awa == ITBS_OFS_ENA);

    always_comb begin
        n = s;
        set_v = '0;
        clr_sw = '0;
        svc = '0;
        n.cmp_prev = cmp_out;
        n.osc_prev = tbase_osc_clk;
        n.src_prev = group_src_flags;
        n.div4 = s.div4 + 2'h1;

        // event capture
        set_v[ITBS_F_CMP] = cmp_out ^ s.cmp_prev;
        for (int g = 0; g < ITBS_NGRP; g++) begin
            set_v[ITBS_F_GRP + g] = |(group_src_flags[g] & ~s.src_prev[g]);
        end
        set_v[ITBS_F_CONV] = conv_done;
        set_v[ITBS_F_TBA] = tba_ovf;
        set_v[ITBS_F_TBB] = tbb_ovf;

        // write channel: address and data accepted in either order
        case (s.wst)
            ITBS_WR_IDLE: begin
                if (axi_req.awvalid && !s.awv) begin
                    n.awv = 1'b1;
                    n.awa = axi_req.awaddr;
                end
                if (axi_req.wvalid && !s.wv) begin
                    n.wv = 1'b1;
                    n.wd = axi_req.wdata[7:0];
                    n.wst0 = axi_req.wstrb[0];
                end
                if (s.awv && s.wv) begin
                    n.awv = 1'b0;
                    n.wv = 1'b0;
                    n.wst = ITBS_WR_RESP;
                    n.bresp = is_mapped(s.awa) ? ITBS_RESP_OKAY : ITBS_RESP_SLVERR;
                    if (s.wst0) begin
                        case (s.awa)
                            ITBS_OFS_ENA: begin
                                n.ena = s.wd;
                            end
                            ITBS_OFS_FLAG: begin
                                clr_sw = s.wd[6:0];
                            end
                            ITBS_OFS_TBC: begin
                                n.time_base_control = s.wd;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            ITBS_WR_RESP: begin
                if (axi_req.bready) begin
                    n.wst = ITBS_WR_IDLE;
                end
            end
            default: begin
                n.wst = ITBS_WR_IDLE;
            end
        endcase

        // read channel
        if (s.rv) begin
            if (axi_req.rready) begin
                n.rv = 1'b0;
            end
        end else if (axi_req.arvalid) begin
            n.rv = 1'b1;
            n.rd = '0;
            n.rresp = is_mapped(axi_req.araddr) ? ITBS_RESP_OKAY : ITBS_RESP_SLVERR;
            case (axi_req.araddr)
                ITBS_OFS_ENA: begin
                    n.rd[7:0] = s.ena;
                end
                ITBS_OFS_FLAG: begin
                    n.rd[6:0] = s.flag;
                end
                ITBS_OFS_TBC: begin
                    n.rd[7:0] = s.time_base_control;
                end
                ITBS_OFS_STAT: begin
                    n.rd[4:0] = {vec_id, vec_req, stack_full};
                end
                default: begin
                end
            endcase
        end

        // global enable: return sets it, a taken call clears it last
        if (irq_return_instr) begin
            n.ena[ITBS_ENA_GIE] = 1'b1;
        end
        if (svc_go) begin
            svc[vec_id] = 1'b1;
            n.ena[ITBS_ENA_GIE] = 1'b0;
        end

        // a new event in the clearing cycle survives
        n.flag = (s.flag & ~clr_sw & ~svc) | set_v;
        n.wake = |(set_v & ~s.flag);
        pend_n = n.flag & n.ena[6:0];
        n.vid = pick(pend_n);
    end

    // a call is offered only with a free stack and the global enable set
    assign vec_req = (|(s.flag & s.ena[6:0])) && s.ena[ITBS_ENA_GIE] && !stack_full;
    assign vec_id = s.vid;
    assign wake_pulse = s.wake;
    assign slow_xtal_low_power = s.time_base_control[ITBS_TBC_LP];

    always_comb begin
        axi_rsp = '0;
        axi_rsp.awready = (s.wst == ITBS_WR_IDLE) && !s.awv;
        axi_rsp.wready = (s.wst == ITBS_WR_IDLE) && !s.wv;
        axi_rsp.bvalid = (s.wst == ITBS_WR_RESP);
        axi_rsp.bresp = s.bresp;
        axi_rsp.arready = !s.rv;
        axi_rsp.rvalid = s.rv;
        axi_rsp.rdata = s.rd;
        axi_rsp.rresp = s.rresp;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.time_base_control <= ITBS_TBC_RST;
            s.wst <= ITBS_WR_IDLE;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    chk_cmp_edge_flag: assert property (
        (cmp_out != s.cmp_prev) |=> s.flag[ITBS_F_CMP])
        else $error("comparator change did not set its flag");

    chk_call_gating: assert property (
        vec_req |-> s.ena[ITBS_ENA_GIE] && s.ena[vec_id] && s.flag[vec_id])
        else $error("call offered without enable and flag");

    chk_svc_clears: assert property (
        svc_go && !set_v[vec_id] |=> !s.flag[$past(vec_id)] && !s.ena[ITBS_ENA_GIE])
        else $error("service did not clear flag and global enable");

    chk_group_set: assert property (
        (|(group_src_flags[0] & ~s.src_prev[0])) |=> s.flag[ITBS_F_GRP])
        else $error("member rise did not set group flag");

    chk_conv_flag: assert property (
        conv_done |=> s.flag[ITBS_F_CONV])
        else $error("conversion end did not set its flag");

    chk_tb_flag_set: assert property (
        tba_ovf ##1 !$past(svc[ITBS_F_TBA]) |-> s.flag[ITBS_F_TBA])
        else $error("time base overflow did not set its flag");

    chk_tb_stopped: assert property (
        !s.time_base_control[ITBS_TBC_RUN] && !s.flag[ITBS_F_TBA] && !s.flag[ITBS_F_TBB]
        |=> !s.flag[ITBS_F_TBA] && !s.flag[ITBS_F_TBB])
        else $error("time base overflow while stopped");

    chk_full_blocks: assert property (
        stack_full |-> !vec_req)
        else $error("call offered while stack full");

    chk_wake_rise: assert property (
        (|(set_v & ~s.flag)) |=> wake_pulse)
        else $error("flag rise gave no wake pulse");

    chk_return_gie: assert property (
        irq_return_instr && !svc_go |=> s.ena[ITBS_ENA_GIE])
        else $error("interrupt return did not set global enable");

    chk_one_call: assert property (
        svc_go |=> !vec_req)
        else $error("second call offered right after service");

    for (genvar gi = 0; gi < ITBS_NGRP; gi++) begin : g_grp_chk
        chk_grp_rise: assert property (
            (|(group_src_flags[gi] & ~s.src_prev[gi])) |=> s.flag[ITBS_F_GRP + gi])
            else $error("member rise did not set its group flag");
    end

    chk_grp_svc: assert property (
        svc_go && (vec_id >= 3'(ITBS_F_GRP)) && (vec_id < 3'(ITBS_F_CONV)) && !set_v[vec_id]
        |=> !s.flag[$past(vec_id)] && !s.ena[ITBS_ENA_GIE])
        else $error("group service did not clear its flag and global enable");

    chk_cmp_call: assert property (
        s.flag[ITBS_F_CMP] && s.ena[ITBS_F_CMP] && s.ena[ITBS_ENA_GIE] && !stack_full
        |-> vec_req && (vec_id == 3'(ITBS_F_CMP)))
        else $error("pending comparator request not offered first");

    chk_conv_call: assert property (
        s.flag[ITBS_F_CONV] && s.ena[ITBS_F_CONV] && s.ena[ITBS_ENA_GIE] && !stack_full
        |-> vec_req)
        else $error("pending converter request not offered");

    chk_conv_svc: assert property (
        svc_go && (vec_id == 3'(ITBS_F_CONV)) && !conv_done
        |=> !s.flag[ITBS_F_CONV] && !s.ena[ITBS_ENA_GIE])
        else $error("converter service did not clear flag and global enable");

    chk_tbb_flag_set: assert property (
        tbb_ovf |=> s.flag[ITBS_F_TBB])
        else $error("second time base overflow did not set its flag");

    chk_tb_call: assert property (
        s.flag[ITBS_F_TBB] && s.ena[ITBS_F_TBB] && s.ena[ITBS_ENA_GIE] && !stack_full
        |-> vec_req)
        else $error("pending time base request not offered");

    chk_tb_svc: assert property (
        svc_go && (vec_id == 3'(ITBS_F_TBA) || vec_id == 3'(ITBS_F_TBB)) && !set_v[vec_id]
        |=> !s.flag[$past(vec_id)] && !s.ena[ITBS_ENA_GIE])
        else $error("time base service did not clear flag and global enable");

    chk_tick_rate: assert property (
        s.time_base_control[ITBS_TBC_CKS] && tb_tick
        |=> (!tb_tick || !s.time_base_control[ITBS_TBC_CKS]) [*3] ##1 (tb_tick || !s.time_base_control[ITBS_TBC_CKS]))
        else $error("system clock over four tick off rate");

    chk_wake_quiet: assert property (
        !(|(set_v & ~s.flag)) |=> !wake_pulse)
        else $error("wake pulse without a flag rise");

    chk_gie_held: assert property (
        !s.ena[ITBS_ENA_GIE] && !irq_return_instr && !ena_wr |=> !s.ena[ITBS_ENA_GIE])
        else $error("global enable rose without a return or a write");

    chk_prio_pick: assert property (
        vec_req |-> (s.flag & s.ena[6:0] & ((7'h01 << vec_id) - 7'h01)) == 7'h00)
        else $error("call offered while a higher priority request waits");

    chk_pend_kept: assert property (
        svc_go && (clr_sw == 7'h00) |=> ($past(s.flag) & ~$past(svc) & ~s.flag) == 7'h00)
        else $error("service dropped another pending request");

    chk_wr_refused: assert property (
        axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write channel ready while a response is pending");

    chk_rd_refused: assert property (
        axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read address ready while read data is pending");

    cov_service: cover property (svc_go ##1 irq_return_instr);
    cov_tb_over: cover property (tba_ovf && s.ena[ITBS_F_TBA]);
    cov_two_pend: cover property (vec_req && $countones(s.flag & s.ena[6:0]) > 1);
    cov_wake: cover property (wake_pulse);
    cov_stack_block: cover property (stack_full && s.ena[ITBS_ENA_GIE] && |(s.flag & s.ena[6:0]));
endmodule

// file: verif/itbs_core_model.sv
// core sequencer model: takes each offered call, then returns from it
// assumes vec_req stays offered as a level until vec_ack is seen high
`timescale 1ns/100ps
module itbs_core_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic vec_req,
    input wire logic slow,
    output logic vec_ack,
    output logic irq_return_instr
);
    logic [2:0] wait_q;
    logic [2:0] ret_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_ack <= 1'b0;
            irq_return_instr <= 1'b0;
            wait_q <= 3'h0;
            ret_q <= 3'h0;
        end else begin
            vec_ack <= 1'b0;
            irq_return_instr <= (ret_q == 3'h1);
            if (ret_q != 3'h0) begin
                ret_q <= ret_q - 3'h1;
            end
            // no nesting: the stack never fills from this side
            if (vec_req && !vec_ack && ret_q == 3'h0) begin
                if (wait_q >= (slow ? 3'h3 : 3'h0)) begin
                    vec_ack <= 1'b1;
                    wait_q <= 3'h0;
                    ret_q <= 3'h5;
                end else begin
                    wait_q <= wait_q + 3'h1;
                end
            end else begin
                wait_q <= 3'h0;
            end
        end
    end
endmodule

// file: verif/itbs_top_tb.sv
// testbench for itbs_top: register bus, request sources and calls
// assumes the core model acks every call and returns from it
`timescale 1ns/100ps
module itbs_top_tb import itbs_pkg::*; ();
    localparam logic [1:0] rok = ITBS_RESP_OKAY;
    localparam logic [1:0] rerr = ITBS_RESP_SLVERR;
    logic core_clk, rst_b, cmp_out, conv_done, stack_full;
    logic osc = 1'b0;
    logic vec_req, vec_ack, ret, wake, lp, slow;
    logic [2:0] vec_id;
    logic [2:0][3:0] gsrc;
    itbs_axi_req_t req;
    itbs_axi_rsp_t rsp;
    logic [33:0] r_q[$];
    logic [1:0] b_q[$];
    logic [2:0] v_q[$];
    int n_errors, total_checks, n_wake, exp_wake, seed, g, rv;
    time t_prev, t_last;

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    itbs_top itbs_top_inst (.core_clk(core_clk), .rst_b(rst_b), .axi_req(req),
        .axi_rsp(rsp), .cmp_out(cmp_out), .conv_done(conv_done),
        .group_src_flags(gsrc), .tbase_osc_clk(osc), .stack_full(stack_full),
        .vec_req(vec_req), .vec_id(vec_id), .vec_ack(vec_ack),
        .irq_return_instr(ret), .wake_pulse(wake), .slow_xtal_low_power(lp));
    itbs_core_model itbs_core_model_inst (.core_clk(core_clk), .rst_b(rst_b),
        .vec_req(vec_req), .slow(slow), .vec_ack(vec_ack), .irq_return_instr(ret));

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic bad(input string m);
        n_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad($sformatf("got %h expected %h", got, exp));
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // one bus transfer; the monitor compares the answer against the note
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d,
                        input logic [1:0] r);
        int n;
        logic ha, hw, done;
        n = 0;
        if (wr) begin
            b_q.push_back(r);
            req.awaddr <= a;
            req.wdata <= {24'h000000, d};
            req.awvalid <= 1'b1;
            req.wvalid <= 1'b1;
        end else begin
            r_q.push_back({r, 24'h000000, d});
            req.araddr <= a;
            req.arvalid <= 1'b1;
        end
        do begin
            @(negedge core_clk);
            done = wr ? (b_q.size() == 0) : (r_q.size() == 0);
            ha = wr ? (req.awvalid && rsp.awready) : (req.arvalid && rsp.arready);
            hw = req.wvalid && rsp.wready;
            @(posedge core_clk);
            if (ha && wr) req.awvalid <= 1'b0;
            if (ha && !wr) req.arvalid <= 1'b0;
            if (hw) req.wvalid <= 1'b0;
            n++;
        end while (!done && n < 50);
        if (!done) begin
            bad("bus timeout");
            conclude();
        end
    endtask

    task automatic waitv(input int lim);
        int n;
        n = 0;
        while (v_q.size() != 0 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        if (v_q.size() != 0) begin
            bad("call missing");
            conclude();
        end
    endtask

    always @(posedge core_clk) begin
        osc <= ~osc;
        if (rst_b) begin
            if (rsp.bvalid && req.bready) begin
                if (b_q.size() == 0) bad("stray write answer");
                else chk({32'h0, rsp.bresp}, {32'h0, b_q.pop_front()});
            end
            if (rsp.rvalid && req.rready) begin
                if (r_q.size() == 0) bad("stray read answer");
                else chk({rsp.rresp, rsp.rdata}, r_q.pop_front());
            end
            if (vec_req && vec_ack) begin
                t_prev = t_last;
                t_last = $time;
                if (v_q.size() == 0) bad("unexpected call");
                else chk({31'h0, vec_id}, {31'h0, v_q.pop_front()});
            end
            if (wake) n_wake++;
        end
    end

    initial begin
        seed = 32'hcfba;
        n_errors = 0;
        total_checks = 0;
        n_wake = 0;
        exp_wake = 0;
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        req.wstrb = 4'hF;
        {rst_b, cmp_out, conv_done, stack_full, slow} = 5'h00;
        gsrc = '0;
        wt(2);
        rst_b <= 1'b1;
        xfer(0, ITBS_OFS_ENA, 8'h00, rok);
        xfer(0, ITBS_OFS_TBC, 8'h37, rok);
        xfer(1, 5'h10, 8'hFF, rerr);
        xfer(0, 5'h14, 8'h00, rerr);
        // comparator change with every enable off: flag and wake, no call
        cmp_out <= 1'b1;
        exp_wake++;
        wt(3);
        xfer(0, ITBS_OFS_STAT, 8'h00, rok);
        xfer(0, ITBS_OFS_FLAG, 8'h01, rok);
        xfer(1, ITBS_OFS_FLAG, 8'h01, rok);
        xfer(1, ITBS_OFS_ENA, 8'hFF, rok);
        stack_full <= 1'b1;
        cmp_out <= 1'b0;
        exp_wake++;
        wt(4);
        xfer(0, ITBS_OFS_STAT, 8'h01, rok);
        v_q.push_back(3'h0);
        stack_full <= 1'b0;
        waitv(20);
        wt(8);
        xfer(0, ITBS_OFS_ENA, 8'hFF, rok);
        // two sources at once: comparator first, converter after the return
        v_q.push_back(3'h0);
        v_q.push_back(3'h4);
        cmp_out <= 1'b1;
        conv_done <= 1'b1;
        exp_wake++;
        wt(1);
        conv_done <= 1'b0;
        waitv(40);
        xfer(0, ITBS_OFS_FLAG, 8'h00, rok);
        for (g = 0; g < 3; g++) begin
            wt(8);
            rv = $random(seed);
            slow <= rv[0];
            gsrc[g][rv[2:1]] <= 1'b1;
            v_q.push_back(3'(g + 1));
            exp_wake++;
            waitv(40);
            xfer(0, ITBS_OFS_FLAG, 8'h00, rok);
            gsrc <= '0;
        end
        chk(34'(n_wake), 34'(exp_wake));
        slow <= 1'b0;
        xfer(1, ITBS_OFS_TBC, 8'hC8, rok);
        wt(1);
        chk({33'h0, lp}, 34'h1);
        xfer(1, ITBS_OFS_ENA, 8'hA0, rok);
        repeat (3) v_q.push_back(3'h5);
        waitv(4000);
        chk(34'(t_last - t_prev), 34'(1024 * 25));
        xfer(1, ITBS_OFS_ENA, 8'hC0, rok);
        repeat (2) v_q.push_back(3'h6);
        waitv(40000);
        chk(34'(t_last - t_prev), 34'(16384 * 25));
        // oscillator input: one rising edge every two core clocks
        xfer(1, ITBS_OFS_TBC, 8'h80, rok);
        xfer(1, ITBS_OFS_FLAG, 8'h7F, rok);
        repeat (3) v_q.push_back(3'h5);
        xfer(1, ITBS_OFS_ENA, 8'hA0, rok);
        waitv(2000);
        chk(34'(t_last - t_prev), 34'(256 * 2 * 25));
        // stopped time bases must raise nothing
        xfer(1, ITBS_OFS_TBC, 8'h40, rok);
        xfer(1, ITBS_OFS_FLAG, 8'h7F, rok);
        wt(1100);
        xfer(0, ITBS_OFS_FLAG, 8'h00, rok);
        conclude();
    end
endmodule
